// File: core/cirq_ctl_array.sv
// cirq_ctl_array: master plus eight slave controllers and a polled third tier.
// assumes the bus end paces acknowledge cycles and drives strobes on clk.
`timescale 1ns/100ps
`default_nettype none
module cirq_ctl_array (
  input wire logic clk,
  input wire logic rstn,
  cirq_if.dev bus,
  input wire logic [cirq_pkg::LINES-1:0] requestInputs,
  input wire logic [cirq_pkg::TIER_W-1:0] thirdTierReq,
  input wire logic masterSlaveSelect,
  output logic [2:0] cascAddr
);
  import cirq_pkg::*;

  localparam int SYNC_W = LINES + TIER_W;

  logic [SYNC_W-1:0] reqMeta_r;
  logic [SYNC_W-1:0] reqSync_r;
  logic [LINES-1:0] reqPrev_r;
  logic [LINES-1:0] pending_r;
  logic [LINES-1:0] pending_nxt;
  logic [7:0] vecBase_r;
  logic [7:0] mask_r;
  logic modeMeta_r;
  logic modeMaster_r;
  logic ackPrev_r;
  logic wrPrev_r;
  logic [2:0] cascAddr_r;
  logic [2:0] lineIdx_r;
  logic valid_r;
  logic [7:0] devData_r;
  logic devOe_r;
  logic cpuIrq_r;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  // request pins and third tier pins pass two flops before use
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reqMeta_r <= '0;
      reqSync_r <= '0;
    end else begin
      reqMeta_r <= {thirdTierReq, requestInputs};
      reqSync_r <= reqMeta_r;
    end
  end

  // ----------------------------------------------------------------
  // third tier, polled
  // ----------------------------------------------------------------
  wire logic [TIER_W-1:0] thirdSync = reqSync_r[SYNC_W-1:LINES];
  wire logic thirdAny;
  wire logic [2:0] thirdIdx;
  cirq_prio8 u_third (
    .req(thirdSync),
    .any(thirdAny),
    .idx(thirdIdx)
  );
  // third tier request joins one second tier slave input
  wire logic [LINES-1:0] pollOr = LINES'(thirdAny) << POLL_LINE;
  wire logic [LINES-1:0] reqEff = reqSync_r[LINES-1:0] | pollOr;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  wire logic ackOn = ~bus.irqAckStrobeN;
  wire logic ackStart = ackOn & ackPrev_r;
  wire logic firstAck = ackStart & ~bus.regSelect;
  wire logic secondAck = ackStart & bus.regSelect;
  wire logic wrStart = ~bus.csN & ~bus.wrN & wrPrev_r;
  wire logic rdOn = ~bus.csN & ~bus.rdN;

  // ----------------------------------------------------------------
  // per-slave arbitration on live pending requests
  // ----------------------------------------------------------------
  logic [SLAVES-1:0] slaveAny;
  logic [SLAVES-1:0] slaveLive;
  logic [2:0] slaveIdx [SLAVES];
  genvar s;
  generate
    for (s = 0; s < SLAVES; s++) begin : g_slave
      // each slave resolves its eight inputs into one request
      cirq_prio8 u_slave (
        .req(pending_r[s*8 +: 8]),
        .any(slaveAny[s]),
        .idx(slaveIdx[s])
      );
      // slave output feeds master input s
      assign slaveLive[s] = |pending_r[s*8 +: 8];
    end
  endgenerate

  // master resolves among unmasked slaves
  wire logic masterAny;
  wire logic [2:0] masterIdx;
  cirq_prio8 u_master (
    .req(slaveAny & ~mask_r),
    .any(masterAny),
    .idx(masterIdx)
  );

  // ----------------------------------------------------------------
  // pending latch and acknowledge clear
  // ----------------------------------------------------------------
  wire logic [5:0] ackLine = {cascAddr_r, lineIdx_r};
  wire logic doClr = secondAck & valid_r & modeMaster_r;
  wire logic [LINES-1:0] ackClr = doClr ? (LINES'(1) << ackLine) : '0;
  // a new edge in the clear cycle survives: set wins
  assign pending_nxt = (pending_r & ~ackClr) | (reqEff & ~reqPrev_r);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reqPrev_r <= '0;
      pending_r <= '0;
    end else begin
      reqPrev_r <= reqEff;
      pending_r <= pending_nxt;
    end
  end

  // ----------------------------------------------------------------
  // acknowledge sequencing
  // ----------------------------------------------------------------
  // first cycle freezes the current pick of slave and line
  // arbitration reads live pending, but later edges cannot move the frozen pick
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cascAddr_r <= 3'h0;
      lineIdx_r <= 3'h0;
      valid_r <= 1'b0;
    end else if (firstAck && modeMaster_r) begin
      cascAddr_r <= masterIdx;
      lineIdx_r <= slaveIdx[masterIdx];
      valid_r <= masterAny;
    end
  end

  // master role from the select pin through two flops
  // edge history resets to the idle high level: no false edge after reset
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      modeMeta_r <= 1'b0;
      modeMaster_r <= 1'b0;
      ackPrev_r <= 1'b1;
      wrPrev_r <= 1'b1;
    end else begin
      modeMeta_r <= masterSlaveSelect;
      modeMaster_r <= modeMeta_r;
      ackPrev_r <= ~ackOn;
      wrPrev_r <= bus.wrN | bus.csN;
    end
  end

  // ----------------------------------------------------------------
  // programming writes
  // ----------------------------------------------------------------
  // select 0 writes vector base, select 1 writes slave mask
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      vecBase_r <= VEC_BASE_RST;
      mask_r <= MASK_RST;
    end else if (wrStart) begin
      if (bus.regSelect) begin
        mask_r <= bus.dataBus;
      end else begin
        vecBase_r <= bus.dataBus;
      end
    end
  end

  // ----------------------------------------------------------------
  // data drive
  // ----------------------------------------------------------------
  // vector names slave and line; spurious code when nothing was frozen
  wire logic [5:0] vecLow = valid_r ? ackLine : SPUR_LOW;
  wire logic [7:0] vecWord = {vecBase_r[7:6], vecLow};
  wire logic [7:0] pollWord = {thirdAny, POLL_PAD, thirdIdx};
  wire logic [7:0] rdWord = bus.regSelect ? pollWord : slaveLive;
  // drive only during second acknowledge or a chip select read
  wire logic vecDrive = ackOn & bus.regSelect & modeMaster_r;
  wire logic devOe_nxt = vecDrive | rdOn;
  wire logic [7:0] devData_nxt = vecDrive ? vecWord : rdWord;
  // interrupt output to the processor from unmasked live slaves
  wire logic cpuIrq_nxt = modeMaster_r & |(slaveLive & ~mask_r);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      devData_r <= 8'h00;
      devOe_r <= 1'b0;
      cpuIrq_r <= 1'b0;
    end else begin
      devData_r <= devData_nxt;
      devOe_r <= devOe_nxt;
      cpuIrq_r <= cpuIrq_nxt;
    end
  end

  assign bus.devData = devData_r;
  assign bus.devOe = devOe_r;
  assign bus.cpuIrqIn = cpuIrq_r;
  assign cascAddr = cascAddr_r;
endmodule : cirq_ctl_array
`default_nettype wire

// File: pkg/cirq_pkg.sv
// cirq_pkg: shared constants and state codes for the cascaded interrupt
// acknowledge link; assumes one clock shared by the bus end and controller end.
package cirq_pkg;
  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int SLAVES = 8;
  localparam int LINES = 64;
  localparam int TIER_W = 8;
  localparam int VEC_W = 8;
  // ----------------------------------------------------------------
  // controller fields and reset values
  // ----------------------------------------------------------------
  localparam logic [5:0] POLL_LINE = 6'h3f;
  localparam logic [5:0] SPUR_LOW = 6'h3f;
  localparam logic [7:0] VEC_BASE_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [3:0] POLL_PAD = 4'h0;
  // ----------------------------------------------------------------
  // io decode: two adjacent doublewords, select from address bit 2
  // ----------------------------------------------------------------
  localparam logic [15:0] IO_BASE = 16'h0020;
  localparam int IO_DEC_LSB = 3;
  localparam int SEL_BIT = 2;
  // ----------------------------------------------------------------
  // timing counts in clk cycles
  // ----------------------------------------------------------------
  localparam int WAIT_STATES = 1;
  localparam logic [2:0] ACK_LEN = 3'(1 + WAIT_STATES);
  localparam logic [2:0] IO_LEN = 3'(1 + WAIT_STATES);
  localparam logic [2:0] IDLE_GAP = 3'h4;
  // ----------------------------------------------------------------
  // bus end states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    H_IDLE = 3'b000,
    H_IO = 3'b001,
    H_ACK1 = 3'b010,
    H_GAP = 3'b011,
    H_ACK2 = 3'b100
  } cirq_hstate_t;
endpackage : cirq_pkg

// File: pkg/cirq_if.sv
// cirq_if: strobes, select and shared data bus between the bus end and the
// controller end; the bus value is resolved here from the two enables.
`timescale 1ns/100ps
`default_nettype none
interface cirq_if;
  logic csN;
  logic rdN;
  logic wrN;
  logic irqAckStrobeN;
  logic regSelect;
  logic [7:0] hostData;
  logic hostOe;
  logic [7:0] devData;
  logic devOe;
  logic cpuIrqIn;
  logic [7:0] dataBus;

  // controller driver wins; undriven bus reads as zero
  assign dataBus = devOe ? devData : (hostOe ? hostData : 8'h00);

  modport dev (
    input csN, rdN, wrN, irqAckStrobeN, regSelect, dataBus,
    output devData, devOe, cpuIrqIn
  );
  modport host (
    output csN, rdN, wrN, irqAckStrobeN, regSelect, hostData, hostOe,
    input dataBus, cpuIrqIn
  );
endinterface : cirq_if
`default_nettype wire

// File: core/cirq_prio8.sv
// cirq_prio8: eight-input fixed priority picker, input 0 highest.
// purely combinational; caller registers what it needs.
`timescale 1ns/100ps
`default_nettype none
module cirq_prio8 (
  input wire logic [7:0] req,
  output logic any,
  output logic [2:0] idx
);
  // ----------------------------------------------------------------
  // priority scan
  // ----------------------------------------------------------------
  // scan downward so the lowest set input wins
  always_comb begin
    idx = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (req[i]) begin
        idx = 3'(i);
      end
    end
  end

  assign any = |req;
endmodule : cirq_prio8
`default_nettype wire

// File: core/cirq_bus_ctl.sv
// cirq_bus_ctl: processor-side decode and strobe sequencer for the controllers.
// assumes the core requests an acknowledge only at an instruction boundary.
`timescale 1ns/100ps
`default_nettype none
module cirq_bus_ctl (
  input wire logic clk,
  input wire logic rstn,
  cirq_if.host bus,
  input wire logic ackGo,
  input wire logic ioGo,
  input wire logic ioWrite,
  input wire logic [15:0] ioAddr,
  input wire logic [7:0] ioWdata,
  output logic irqReq,
  output logic busy,
  output logic [7:0] ioRdata,
  output logic ioDone,
  output logic [7:0] vector,
  output logic vectorValid
);
  import cirq_pkg::*;

  cirq_hstate_t state_r;
  logic [2:0] cnt_r;
  logic csN_r;
  logic rdN_r;
  logic wrN_r;
  logic ackN_r;
  logic regSel_r;
  logic [7:0] hostData_r;
  logic hostOe_r;
  logic irqReq_r;
  logic busy_r;
  logic [7:0] ioRdata_r;
  logic ioDone_r;
  logic [7:0] vector_r;
  logic vectorValid_r;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  // two doublewords at base, select from address bit 2
  wire logic ioHit = ioAddr[15:IO_DEC_LSB] == IO_BASE[15:IO_DEC_LSB];
  wire logic ioSel = ioAddr[SEL_BIT];
  wire logic cntZero = cnt_r == 3'h0;

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= H_IDLE;
      cnt_r <= 3'h0;
      csN_r <= 1'b1;
      rdN_r <= 1'b1;
      wrN_r <= 1'b1;
      ackN_r <= 1'b1;
      regSel_r <= 1'b0;
      hostData_r <= 8'h00;
      hostOe_r <= 1'b0;
      busy_r <= 1'b0;
      ioRdata_r <= 8'h00;
      ioDone_r <= 1'b0;
      vector_r <= 8'h00;
      vectorValid_r <= 1'b0;
    end else begin
      ioDone_r <= 1'b0;
      vectorValid_r <= 1'b0;
      case (state_r)
        H_IDLE: begin
          if (ackGo) begin
            // first acknowledge, select low, stretched by a wait state
            state_r <= H_ACK1;
            ackN_r <= 1'b0;
            regSel_r <= 1'b0;
            cnt_r <= ACK_LEN - 3'h1;
            busy_r <= 1'b1;
          end else if (ioGo) begin
            state_r <= H_IO;
            csN_r <= ~ioHit;
            regSel_r <= ioSel;
            rdN_r <= ioWrite;
            wrN_r <= ~ioWrite;
            hostData_r <= ioWdata;
            hostOe_r <= ioWrite;
            cnt_r <= IO_LEN - 3'h1;
            busy_r <= 1'b1;
          end
        end
        H_IO: begin
          if (cntZero) begin
            state_r <= H_IDLE;
            csN_r <= 1'b1;
            rdN_r <= 1'b1;
            wrN_r <= 1'b1;
            hostOe_r <= 1'b0;
            ioRdata_r <= bus.dataBus;
            ioDone_r <= 1'b1;
            busy_r <= 1'b0;
          end else begin
            cnt_r <= cnt_r - 3'h1;
          end
        end
        H_ACK1: begin
          // data of the first cycle is not sampled
          if (cntZero) begin
            state_r <= H_GAP;
            ackN_r <= 1'b1;
            cnt_r <= IDLE_GAP - 3'h1;
          end else begin
            cnt_r <= cnt_r - 3'h1;
          end
        end
        H_GAP: begin
          // four idle cycles between the two acknowledges
          if (cntZero) begin
            state_r <= H_ACK2;
            ackN_r <= 1'b0;
            regSel_r <= 1'b1;
            cnt_r <= ACK_LEN - 3'h1;
          end else begin
            cnt_r <= cnt_r - 3'h1;
          end
        end
        H_ACK2: begin
          // vector taken on the last strobe cycle
          if (cntZero) begin
            state_r <= H_IDLE;
            ackN_r <= 1'b1;
            regSel_r <= 1'b0;
            vector_r <= bus.dataBus;
            vectorValid_r <= 1'b1;
            busy_r <= 1'b0;
          end else begin
            cnt_r <= cnt_r - 3'h1;
          end
        end
        default: begin
          state_r <= H_IDLE;
        end
      endcase
    end
  end

  // interrupt level passed to the core, registered
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irqReq_r <= 1'b0;
    end else begin
      irqReq_r <= bus.cpuIrqIn;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign bus.csN = csN_r;
  assign bus.rdN = rdN_r;
  assign bus.wrN = wrN_r;
  assign bus.irqAckStrobeN = ackN_r;
  assign bus.regSelect = regSel_r;
  assign bus.hostData = hostData_r;
  assign bus.hostOe = hostOe_r;
  assign irqReq = irqReq_r;
  assign busy = busy_r;
  assign ioRdata = ioRdata_r;
  assign ioDone = ioDone_r;
  assign vector = vector_r;
  assign vectorValid = vectorValid_r;
endmodule : cirq_bus_ctl
`default_nettype wire

// File: test/cirq_asserts.sv
// cirq_asserts: timing checks on the link between bus end and controllers
// assumes one clock; placed beside the interface by the testbench
`timescale 1ns/100ps
`default_nettype none
module cirq_asserts (
  input wire logic clk,
  input wire logic rstn,
  input wire logic rdN,
  input wire logic wrN,
  input wire logic irqAckStrobeN,
  input wire logic regSelect,
  input wire logic hostOe,
  input wire logic [7:0] devData,
  input wire logic devOe
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  // ----------------
  // sequences
  // ----------------
  sequence s_ack1End;
    !irqAckStrobeN && !regSelect ##1 irqAckStrobeN;
  endsequence
  sequence s_gapAck2;
    irqAckStrobeN [*4] ##1 (!irqAckStrobeN && regSelect);
  endsequence
  sequence s_vecDrive;
    !irqAckStrobeN ##1 (irqAckStrobeN && devOe) ##1 !devOe;
  endsequence
  // ----------------
  // properties
  // ----------------
  property p_ackWait;
    $fell(irqAckStrobeN) |-> !irqAckStrobeN [*2] ##1 irqAckStrobeN;
  endproperty
  property p_ackGap;
    s_ack1End |-> s_gapAck2;
  endproperty
  property p_ack2Drive;
    $rose(devOe) && !irqAckStrobeN |-> s_vecDrive;
  endproperty
  property p_ack1Quiet;
    !irqAckStrobeN && !regSelect |-> !devOe;
  endproperty
  property p_vecWindow;
    devOe |-> (!$past(irqAckStrobeN) && $past(regSelect)) || !$past(rdN);
  endproperty
  property p_hostQuiet;
    !irqAckStrobeN |-> !hostOe;
  endproperty
  property p_ioHold;
    $fell(rdN) || $fell(wrN) |-> ##1 (!rdN || !wrN) ##1 (rdN && wrN);
  endproperty
  property p_oneStrobe;
    $onehot0({!rdN, !wrN, !irqAckStrobeN});
  endproperty
  property p_vecStable;
    devOe && $past(devOe) |-> $stable(devData);
  endproperty
  // ----------------
  // assertions
  // ----------------
  a_ackWait: assert property (p_ackWait)
    else $error("ack strobe length wrong");
  a_ackGap: assert property (p_ackGap)
    else $error("idle gap between acks wrong");
  a_ack2Drive: assert property (p_ack2Drive)
    else $error("vector drive window wrong");
  a_ack1Quiet: assert property (p_ack1Quiet)
    else $error("data driven in first ack");
  a_vecWindow: assert property (p_vecWindow)
    else $error("controller drives outside strobe");
  a_hostQuiet: assert property (p_hostQuiet)
    else $error("bus end drives during ack");
  a_ioHold: assert property (p_ioHold)
    else $error("io strobe length wrong");
  a_oneStrobe: assert property (p_oneStrobe)
    else $error("two strobes active");
  a_vecStable: assert property (p_vecStable)
    else $error("driven data changed");
endmodule : cirq_asserts
`default_nettype wire

// File: test/testbench.sv
// testbench: drives bus end and request pins, models the controllers
// assumes package, interface and both ends compiled first
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import cirq_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic ackGo = 1'b0;
  logic ioGo = 1'b0;
  logic ioWrite = 1'b0;
  logic masterSlaveSelect = 1'b1;
  logic [15:0] ioAddr = 16'h0000;
  logic [7:0] ioWdata = 8'h00;
  logic [63:0] requestInputs = 64'h0;
  logic [7:0] thirdTierReq = 8'h00;
  logic irqReq, busy, ioDone, vectorValid;
  logic [7:0] ioRdata, vector, got;
  logic [2:0] cascAddr;
  logic [63:0] pend = 64'h0;
  logic [7:0] base = VEC_BASE_RST;
  logic [7:0] mask = MASK_RST;
  integer bad_count = 0;
  integer total_checks = 0;
  integer seed = 32'h3aad;
  integer i;
  // ----------------
  // clock and design
  // ----------------
  always #20 clk = ~clk;
  cirq_if bus ();
  cirq_ctl_array u_cirq_ctl_array (.clk(clk), .rstn(rstn), .bus(bus),
    .requestInputs(requestInputs), .thirdTierReq(thirdTierReq),
    .masterSlaveSelect(masterSlaveSelect), .cascAddr(cascAddr));
  cirq_bus_ctl u_cirq_bus_ctl (.clk(clk), .rstn(rstn), .bus(bus), .ackGo(ackGo),
    .ioGo(ioGo), .ioWrite(ioWrite), .ioAddr(ioAddr), .ioWdata(ioWdata),
    .irqReq(irqReq), .busy(busy), .ioRdata(ioRdata), .ioDone(ioDone),
    .vector(vector), .vectorValid(vectorValid));
  cirq_asserts u_cirq_asserts (.clk(clk), .rstn(rstn), .rdN(bus.rdN), .wrN(bus.wrN),
    .irqAckStrobeN(bus.irqAckStrobeN), .regSelect(bus.regSelect),
    .hostOe(bus.hostOe), .devData(bus.devData), .devOe(bus.devOe));
  // ----------------
  // model and tasks
  // ----------------
  task automatic check(input logic [7:0] exp, input logic [7:0] act);
    total_checks++;
    if (act !== exp) begin
      bad_count++;
      $display("mismatch at %0t: expected %h got %h", $time, exp, act);
    end
  endtask : check
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : complete_run
  // lowest unmasked slave, then lowest line: {found, slave, line}
  function automatic logic [6:0] pick();
    for (int s = 0; s < SLAVES; s++) begin
      for (int l = 0; l < 8; l++) begin
        if (!mask[s] && pend[s*8+l]) return {1'b1, 3'(s), 3'(l)};
      end
    end
    return 7'h0;
  endfunction : pick
  function automatic logic [7:0] summ();
    logic [7:0] r;
    for (int s = 0; s < 8; s++) r[s] = |pend[s*8 +: 8];
    return r;
  endfunction : summ
  // rising pin edges latch into pending
  task automatic drive_req(input logic [63:0] r);
    pend = pend | (r & ~requestInputs);
    requestInputs = r;
  endtask : drive_req
  task automatic run_ack(input int late);
    logic [6:0] p;
    int n;
    p = pick();
    @(negedge clk);
    ackGo = 1'b1;
    @(negedge clk);
    ackGo = 1'b0;
    if (late >= 0) begin
      @(negedge clk);
      drive_req(64'h1 << late);
    end
    for (n = 0; n < 20 && vectorValid !== 1'b1; n++) @(negedge clk);
    if (n == 20) begin
      bad_count++;
      complete_run();
    end
    check(p[6] ? {base[7:6], p[5:0]} : {base[7:6], SPUR_LOW}, vector);
    if (p[6]) begin
      check({5'h0, p[5:3]}, {5'h0, cascAddr});
      pend[p[5:0]] = 1'b0;
    end
  endtask : run_ack
  task automatic run_io(input logic wr, input logic [15:0] a, input logic [7:0] d);
    int n;
    @(negedge clk);
    ioGo = 1'b1;
    ioWrite = wr;
    ioAddr = a;
    ioWdata = d;
    @(negedge clk);
    ioGo = 1'b0;
    check(8'h01, {7'h0, busy});
    check({7'h0, bus.regSelect}, {7'h0, a[2]});
    check({7'h0, bus.csN}, {7'h0, a[15:3] != IO_BASE[15:3]});
    for (n = 0; n < 20 && ioDone !== 1'b1; n++) @(negedge clk);
    if (n == 20) begin
      bad_count++;
      complete_run();
    end
    got = ioRdata;
    if (wr && a[15:3] == IO_BASE[15:3]) begin
      if (a[2]) mask = d;
      else base = d;
    end
  endtask : run_io
  // ----------------
  // main sequence
  // ----------------
  initial begin
    repeat (20) @(negedge clk);
    rstn = 1'b1;
    repeat (4) @(negedge clk);
    check({7'h0, irqReq}, 8'h00);
    run_ack(-1);
    run_io(1'b1, IO_BASE, 8'hc0);
    run_io(1'b1, IO_BASE + 16'h14, 8'hff);
    for (i = 0; i < 6; i++) begin
      drive_req({$random(seed), $random(seed)} & 64'h7fff_ffff_ffff_ffff);
      repeat (6) @(negedge clk);
      check({7'h0, irqReq}, {7'h0, |pend});
      run_io(1'b0, IO_BASE, 8'h00);
      check(summ(), got);
      run_ack(-1);
      drive_req(64'h0);
      repeat (2) @(negedge clk);
    end
    for (i = 0; i < 70 && pend != 64'h0; i++) run_ack(-1);
    repeat (4) @(negedge clk);
    check({7'h0, irqReq}, 8'h00);
    drive_req(64'h8000);
    repeat (6) @(negedge clk);
    run_ack(0);
    run_ack(-1);
    drive_req(64'h0);
    run_io(1'b1, IO_BASE + 16'h4, 8'h01);
    drive_req(64'h2_0002);
    repeat (6) @(negedge clk);
    run_ack(-1);
    repeat (4) @(negedge clk);
    check({7'h0, irqReq}, 8'h00);
    run_io(1'b1, IO_BASE + 16'h4, 8'h00);
    repeat (6) @(negedge clk);
    check({7'h0, irqReq}, 8'h01);
    run_ack(-1);
    drive_req(64'h0);
    thirdTierReq = 8'h0c;
    pend[63] = 1'b1;
    repeat (6) @(negedge clk);
    run_io(1'b0, IO_BASE + 16'h4, 8'h00);
    check(8'h82, got);
    run_ack(-1);
    thirdTierReq = 8'h00;
    repeat (2) @(negedge clk);
    rstn = 1'b0;
    pend = 64'h0;
    base = VEC_BASE_RST;
    mask = MASK_RST;
    masterSlaveSelect = 1'b0;
    repeat (3) @(negedge clk);
    rstn = 1'b1;
    repeat (3) @(negedge clk);
    drive_req(64'h20);
    repeat (6) @(negedge clk);
    check({7'h0, irqReq}, 8'h00);
    complete_run();
  end
endmodule : testbench
`default_nettype wire
